// File: hw/spc_pkg.sv
// package: constants and types shared by host and sensor control ends
// Notes on behaviour
// - first power-up loads default profile, starts it
// - running profile sends its default message type
// - settings change refused while profile runs
// - host: stop, load, set, then start
// - settings committed only at profile start
// - uncommitted settings lost on power loss
// - reset-needing profile start: error, apply, reset
// - host waits seconds after error before retry
// - retry after self-reset replies ok, runs
// - profile switch restores its last settings
// - later resets resume last committed configuration
// - unused io pins pulled up, left open
// - boot loader erase or alter always rejected
// - boot loader entered by command or pin
// - host restarts failed upgrade from beginning
// - ten consecutive firmware resets enter fail-safe
// - fail-safe drives status led white
// - fail-safe answers only low-level commands
// - reset command or power cycle leaves fail-safe
// - fast window 6 s, slow 20 or 15
package spc_pkg;
    localparam int SPC_NPROF = 4;
    localparam int SPC_SETW  = 16;
    localparam int SPC_IOW   = 4;
    localparam int SPC_CLK_HZ        = 40_000_000;
    localparam int SPC_FAST_S        = 6;
    localparam int SPC_SLOW_ADULT_S  = 20;
    localparam int SPC_SLOW_BABY_S   = 15;
    localparam int SPC_RETRY_WAIT_S  = 2;
    localparam int SPC_FAULT_LIMIT   = 10;
    localparam logic [3:0] SPC_FAULT_LIMIT_W = 4'hA;
    localparam logic [1:0] SPC_DEFAULT_PROF = 2'h0;
    localparam logic [SPC_SETW-1:0] SPC_DEFAULT_SET = 16'h0005;
    // per profile: reset group (mcu reset when a start crosses groups), is baby profile
    localparam logic [SPC_NPROF-1:0] SPC_PROF_RESET = 4'hC;
    localparam logic [SPC_NPROF-1:0] SPC_PROF_BABY  = 4'hA;
    // io pins used by each profile, one nibble per profile
    localparam logic [15:0] SPC_PROF_IO = 16'h3737;
    localparam logic [2:0]  SPC_LED_OFF   = 3'h0;
    localparam logic [2:0]  SPC_LED_WHITE = 3'h7;
    localparam logic [2:0]  SPC_LED_BLUE  = 3'h1;

    typedef enum logic [3:0] {
        SPC_CMD_NONE, SPC_CMD_STOP, SPC_CMD_LOAD, SPC_CMD_SET,
        SPC_CMD_START, SPC_CMD_BOOT, SPC_CMD_RESET, SPC_CMD_ERASE_BOOT,
        SPC_CMD_UPGRADE, SPC_CMD_LOWLEVEL
    } spc_cmd_t;
    typedef enum logic [1:0] {
        SPC_RSP_NONE, SPC_RSP_OK, SPC_RSP_ERROR
    } spc_rsp_t;
endpackage

// File: hw/spc_link_if.sv
// interface: command link between host and sensor control
`timescale 1ns/100ps
interface spc_link_if;
    import spc_pkg::*;
    logic                 cmd_valid;
    spc_cmd_t             cmd;
    logic [1:0]           cmd_prof;
    logic [SPC_SETW-1:0]  cmd_set;
    logic                 rsp_valid;
    spc_rsp_t             rsp;
    logic                 msg_valid;
    logic [1:0]           msg_type;
    logic                 boot_force;
    modport sensor (input cmd_valid, cmd, cmd_prof, cmd_set, boot_force,
                    output rsp_valid, rsp, msg_valid, msg_type);
    modport host   (output cmd_valid, cmd, cmd_prof, cmd_set, boot_force,
                    input rsp_valid, rsp, msg_valid, msg_type);
endinterface // spc_link_if

// File: hw/spc_sensor.sv
// module: sensor end, profile, settings, boot and fail-safe control
`timescale 1ns/100ps
module spc_sensor
    import spc_pkg::*;
(
    input  wire logic           clock,
    input  wire logic           rst_b,
    input  wire logic           power_first,
    input  wire logic           power_loss,
    input  wire logic           fw_fault,
    input  wire logic [SPC_IOW-1:0] io_in,
    spc_link_if.sensor          link,
    output logic                running,
    output logic                fail_safe,
    output logic                boot_mode,
    output logic                mcu_reset,
    output logic [2:0]          led,
    output logic [SPC_IOW-1:0]  io_pullup,
    output logic                fast_tick,
    output logic                slow_tick
);
    localparam logic [31:0] FAST_CYC = 32'(SPC_FAST_S * SPC_CLK_HZ);
    localparam logic [31:0] SLOWA_CYC = 32'(SPC_SLOW_ADULT_S * SPC_CLK_HZ);
    localparam logic [31:0] SLOWB_CYC = 32'(SPC_SLOW_BABY_S * SPC_CLK_HZ);

    // =====================================================
    // state
    // =====================================================
    logic                 run_reg, run_next;
    logic [1:0]           prof_reg, prof_next;
    logic [1:0]           cprof_reg, cprof_next;
    logic [SPC_SETW-1:0]  work_reg, work_next;
    logic [SPC_SETW-1:0]  store_reg [SPC_NPROF];
    logic [SPC_SETW-1:0]  store_next [SPC_NPROF];
    logic [SPC_NPROF-1:0] ran_reg, ran_next;
    logic                 inited_reg, inited_next;
    logic                 rstpend_reg, rstpend_next;
    logic [3:0]           fcnt_reg, fcnt_next;
    logic                 fs_reg, fs_next;
    logic                 boot_reg, boot_next;
    logic                 rv_reg, rv_next;
    spc_rsp_t             rsp_reg, rsp_next;
    logic                 mv_reg, mv_next;
    logic [31:0]          fc_reg, fc_next, sc_reg, sc_next;
    logic                 ft_reg, ft_next, st_reg, st_next;
    logic                 mr_reg, mr_next;
    logic [2:0]           led_reg, led_next;
    logic [SPC_IOW-1:0]   pu_reg, pu_next;
    logic                 cv;
    logic [31:0]          slow_len;

    assign cv = link.cmd_valid;
    assign slow_len = SPC_PROF_BABY[cprof_reg] ? SLOWB_CYC : SLOWA_CYC;

    always_comb begin
        run_next = run_reg;
        prof_next = prof_reg;
        cprof_next = cprof_reg;
        work_next = work_reg;
        store_next = store_reg;
        ran_next = ran_reg;
        inited_next = inited_reg;
        rstpend_next = rstpend_reg;
        fcnt_next = fcnt_reg;
        fs_next = fs_reg;
        boot_next = boot_reg;
        rv_next = 1'b0;
        rsp_next = rsp_reg;
        mr_next = 1'b0;
        if (!inited_reg) begin
            // first power-up default
            prof_next = SPC_DEFAULT_PROF;
            cprof_next = SPC_DEFAULT_PROF;
            work_next = SPC_DEFAULT_SET;
            for (int i = 0; i < SPC_NPROF; i++) begin
                store_next[i] = SPC_DEFAULT_SET;
            end
            ran_next = '0;
            ran_next[SPC_DEFAULT_PROF] = 1'b1;
            run_next = 1'b1;
            inited_next = 1'b1;
        end else if (power_loss || fw_fault) begin
            // restart from committed state, drop pending edits
            prof_next = cprof_reg;
            work_next = store_reg[cprof_reg];
            run_next = 1'b1;
            boot_next = 1'b0;
            rstpend_next = 1'b0;
            if (power_loss) begin
                fcnt_next = 4'h0;
                fs_next = 1'b0;
            end else if (!fs_reg) begin
                fcnt_next = fcnt_reg + 4'h1;
                if (fcnt_reg + 4'h1 >= SPC_FAULT_LIMIT_W) begin
                    fs_next = 1'b1;
                end
            end
        end else if (link.boot_force) begin
            boot_next = 1'b1;
            run_next = 1'b0;
        end else if (cv && fs_reg) begin
            // only low-level commands are served
            case (link.cmd)
                SPC_CMD_RESET: begin
                    fs_next = 1'b0;
                    fcnt_next = 4'h0;
                    mr_next = 1'b1;
                    rv_next = 1'b1;
                    rsp_next = SPC_RSP_OK;
                end
                SPC_CMD_UPGRADE: begin
                    boot_next = 1'b1;
                    rv_next = 1'b1;
                    rsp_next = SPC_RSP_OK;
                end
                SPC_CMD_LOWLEVEL: begin
                    rv_next = 1'b1;
                    rsp_next = SPC_RSP_OK;
                end
                default: ;
            endcase
        end else if (cv) begin
            rv_next = 1'b1;
            rsp_next = SPC_RSP_OK;
            case (link.cmd)
                SPC_CMD_STOP: run_next = 1'b0;
                SPC_CMD_LOAD: begin
                    if (run_reg) begin
                        rsp_next = SPC_RSP_ERROR;
                    end else begin
                        prof_next = link.cmd_prof;
                        // last used settings or defaults
                        work_next = ran_reg[link.cmd_prof] ?
                            store_reg[link.cmd_prof] : SPC_DEFAULT_SET;
                    end
                end
                SPC_CMD_SET: begin
                    if (run_reg) begin
                        rsp_next = SPC_RSP_ERROR;
                    end else begin
                        work_next = link.cmd_set;
                    end
                end
                SPC_CMD_START: begin
                    store_next[prof_reg] = work_reg;
                    ran_next[prof_reg] = 1'b1;
                    cprof_next = prof_reg;
                    if (SPC_PROF_RESET[prof_reg] != SPC_PROF_RESET[cprof_reg]
                        && !rstpend_reg) begin
                        rsp_next = SPC_RSP_ERROR;
                        mr_next = 1'b1;
                        rstpend_next = 1'b1;
                        run_next = 1'b0;
                    end else begin
                        rstpend_next = 1'b0;
                        run_next = 1'b1;
                    end
                end
                SPC_CMD_BOOT: begin
                    boot_next = 1'b1;
                    run_next = 1'b0;
                end
                SPC_CMD_ERASE_BOOT: rsp_next = SPC_RSP_ERROR;
                SPC_CMD_RESET: begin
                    mr_next = 1'b1;
                    fcnt_next = 4'h0;
                    prof_next = cprof_reg;
                    work_next = store_reg[cprof_reg];
                end
                SPC_CMD_UPGRADE: boot_next = 1'b1;
                default: ;
            endcase
        end
    end

    // =====================================================
    // processing windows and outputs
    // =====================================================
    always_comb begin
        fc_next = fc_reg;
        sc_next = sc_reg;
        ft_next = 1'b0;
        st_next = 1'b0;
        if (!run_reg) begin
            fc_next = 32'h0;
            sc_next = 32'h0;
        end else begin
            fc_next = fc_reg + 32'h1;
            sc_next = sc_reg + 32'h1;
            if (fc_reg == FAST_CYC - 32'h1) begin
                fc_next = 32'h0;
                ft_next = 1'b1;
            end
            if (sc_reg >= slow_len - 32'h1) begin
                sc_next = 32'h0;
                st_next = 1'b1;
            end
        end
        mv_next = run_reg && !fs_reg && ft_reg;
        led_next = fs_reg ? SPC_LED_WHITE :
                   (run_reg ? SPC_LED_BLUE : SPC_LED_OFF);
        pu_next = ~SPC_PROF_IO[cprof_reg*4 +: 4];
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            run_reg <= 1'b0;
            prof_reg <= 2'h0;
            cprof_reg <= 2'h0;
            work_reg <= 16'h0000;
            for (int i = 0; i < SPC_NPROF; i++) begin
                store_reg[i] <= 16'h0000;
            end
            ran_reg <= 4'h0;
            inited_reg <= 1'b0;
            rstpend_reg <= 1'b0;
            fcnt_reg <= 4'h0;
            fs_reg <= 1'b0;
            boot_reg <= 1'b0;
            rv_reg <= 1'b0;
            rsp_reg <= SPC_RSP_NONE;
            mv_reg <= 1'b0;
            fc_reg <= 32'h0;
            sc_reg <= 32'h0;
            ft_reg <= 1'b0;
            st_reg <= 1'b0;
            mr_reg <= 1'b0;
            led_reg <= 3'h0;
            pu_reg <= 4'hF;
        end else begin
            run_reg <= run_next;
            prof_reg <= prof_next;
            cprof_reg <= cprof_next;
            work_reg <= work_next;
            store_reg <= store_next;
            ran_reg <= ran_next;
            inited_reg <= inited_next | ~power_first;
            rstpend_reg <= rstpend_next;
            fcnt_reg <= fcnt_next;
            fs_reg <= fs_next;
            boot_reg <= boot_next;
            rv_reg <= rv_next;
            rsp_reg <= rsp_next;
            mv_reg <= mv_next;
            fc_reg <= fc_next;
            sc_reg <= sc_next;
            ft_reg <= ft_next;
            st_reg <= st_next;
            mr_reg <= mr_next;
            led_reg <= led_next;
            pu_reg <= pu_next;
        end
    end

    assign link.rsp_valid = rv_reg;
    assign link.rsp = rsp_reg;
    assign link.msg_valid = mv_reg;
    assign link.msg_type = cprof_reg;
    assign running = run_reg;
    assign fail_safe = fs_reg;
    assign boot_mode = boot_reg;
    assign mcu_reset = mr_reg;
    assign led = led_reg;
    assign io_pullup = pu_reg;
    assign fast_tick = ft_reg;
    assign slow_tick = st_reg;
endmodule // spc_sensor

// File: hw/spc_host.sv
// module: host end, sequences reconfiguration and upgrade retries
`timescale 1ns/100ps
module spc_host
    import spc_pkg::*;
#(
    parameter logic [31:0] RETRY_WAIT = 32'(SPC_RETRY_WAIT_S * SPC_CLK_HZ)
)
(
    input  wire logic           clock,
    input  wire logic           rst_b,
    input  wire logic           cfg_go,
    input  wire logic [1:0]     cfg_prof,
    input  wire logic [SPC_SETW-1:0] cfg_set,
    input  wire logic           upg_go,
    input  wire logic           upg_fail,
    input  wire logic           force_boot,
    spc_link_if.host            link,
    output logic                busy,
    output logic                done,
    output logic                upg_restart
);
    typedef enum logic [2:0] {
        SPC_H_IDLE, SPC_H_STOP, SPC_H_LOAD, SPC_H_SET, SPC_H_START,
        SPC_H_WAITRSP, SPC_H_HOLD
    } spc_hstate_t;

    spc_hstate_t          st_reg, st_next;
    logic                 cv_reg, cv_next;
    spc_cmd_t             cmd_reg, cmd_next;
    logic [1:0]           pr_reg, pr_next;
    logic [SPC_SETW-1:0]  set_reg, set_next;
    logic [31:0]          wt_reg, wt_next;
    logic                 busy_reg, busy_next;
    logic                 done_reg, done_next;
    logic                 ur_reg, ur_next;
    logic                 fb_reg;

    // =====================================================
    // sequencer
    // =====================================================
    always_comb begin
        st_next = st_reg;
        cv_next = 1'b0;
        cmd_next = cmd_reg;
        pr_next = pr_reg;
        set_next = set_reg;
        wt_next = wt_reg;
        done_next = 1'b0;
        ur_next = 1'b0;
        case (st_reg)
            SPC_H_IDLE: begin
                if (upg_fail) begin
                    // whole upgrade again from the start
                    ur_next = 1'b1;
                    cv_next = 1'b1;
                    cmd_next = SPC_CMD_UPGRADE;
                end else if (upg_go) begin
                    cv_next = 1'b1;
                    cmd_next = SPC_CMD_UPGRADE;
                end else if (cfg_go) begin
                    pr_next = cfg_prof;
                    set_next = cfg_set;
                    cv_next = 1'b1;
                    cmd_next = SPC_CMD_STOP;
                    st_next = SPC_H_LOAD;
                end
            end
            SPC_H_LOAD: begin
                cv_next = 1'b1;
                cmd_next = SPC_CMD_LOAD;
                st_next = SPC_H_SET;
            end
            SPC_H_SET: begin
                cv_next = 1'b1;
                cmd_next = SPC_CMD_SET;
                st_next = SPC_H_START;
            end
            SPC_H_START: begin
                cv_next = 1'b1;
                cmd_next = SPC_CMD_START;
                st_next = SPC_H_WAITRSP;
            end
            SPC_H_WAITRSP: begin
                // first cycle still shows the answer to the settings
                if (link.rsp_valid && !cv_reg
                    && link.rsp == SPC_RSP_ERROR) begin
                    wt_next = RETRY_WAIT;
                    st_next = SPC_H_HOLD;
                end else if (link.rsp_valid && !cv_reg) begin
                    done_next = 1'b1;
                    st_next = SPC_H_IDLE;
                end
            end
            SPC_H_HOLD: begin
                wt_next = wt_reg - 32'h1;
                if (wt_reg == 32'h0) begin
                    st_next = SPC_H_LOAD;
                end
            end
            default: st_next = SPC_H_IDLE;
        endcase
        busy_next = (st_next != SPC_H_IDLE);
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= SPC_H_IDLE;
            cv_reg <= 1'b0;
            cmd_reg <= SPC_CMD_NONE;
            pr_reg <= 2'h0;
            set_reg <= 16'h0000;
            wt_reg <= 32'h0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            ur_reg <= 1'b0;
            fb_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            cv_reg <= cv_next;
            cmd_reg <= cmd_next;
            pr_reg <= pr_next;
            set_reg <= set_next;
            wt_reg <= wt_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            ur_reg <= ur_next;
            fb_reg <= force_boot;
        end
    end

    assign link.cmd_valid = cv_reg;
    assign link.cmd = cmd_reg;
    assign link.cmd_prof = pr_reg;
    assign link.cmd_set = set_reg;
    assign link.boot_force = fb_reg;
    assign busy = busy_reg;
    assign done = done_reg;
    assign upg_restart = ur_reg;
endmodule // spc_host

// File: verif/spc_link_monitor.sv
// checker: timing and order of traffic on the host to sensor link
`timescale 1ns/100ps
module spc_link_monitor
    import spc_pkg::*;
(
    input wire logic                clock,
    input wire logic                rst_b,
    input wire logic                cmd_valid,
    input wire spc_cmd_t            cmd,
    input wire logic [1:0]          cmd_prof,
    input wire logic [SPC_SETW-1:0] cmd_set,
    input wire logic                rsp_valid,
    input wire spc_rsp_t            rsp,
    input wire logic                msg_valid,
    input wire logic [1:0]          msg_type,
    input wire logic                boot_force
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    // ==========
    // helper state
    spc_cmd_t   last_cmd_reg,  last_cmd_next;
    logic [1:0] load_prof_reg, load_prof_next;
    logic       err_pend_reg,  err_pend_next;

    always_comb begin
        last_cmd_next  = last_cmd_reg;
        load_prof_next = load_prof_reg;
        err_pend_next  = err_pend_reg;
        if (cmd_valid) begin
            last_cmd_next = cmd;
            if (cmd == SPC_CMD_LOAD) begin
                load_prof_next = cmd_prof;
            end
        end
        if (rsp_valid && last_cmd_reg == SPC_CMD_START) begin
            err_pend_next = (rsp == SPC_RSP_ERROR);
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            last_cmd_reg  <= SPC_CMD_NONE;
            load_prof_reg <= SPC_DEFAULT_PROF;
            err_pend_reg  <= 1'b0;
        end else begin
            last_cmd_reg  <= last_cmd_next;
            load_prof_reg <= load_prof_next;
            err_pend_reg  <= err_pend_next;
        end
    end

    // ==========
    // assertions
    rsp_latency_a: assert property (
        cmd_valid && !boot_force |=> rsp_valid)
        else $error("command not answered one cycle later");
    rsp_cause_a: assert property (
        rsp_valid |-> $past(cmd_valid))
        else $error("answer without a command");
    set_after_load_a: assert property (
        cmd_valid && cmd == SPC_CMD_SET
        |-> $past(cmd_valid) && last_cmd_reg == SPC_CMD_LOAD)
        else $error("settings not preceded by profile load");
    start_after_set_a: assert property (
        cmd_valid && cmd == SPC_CMD_START
        |-> $past(cmd_valid) && last_cmd_reg == SPC_CMD_SET)
        else $error("start not preceded by settings");
    erase_refused_a: assert property (
        rsp_valid && last_cmd_reg == SPC_CMD_ERASE_BOOT
        |-> rsp == SPC_RSP_ERROR)
        else $error("loader erase not refused");
    retry_wait_a: assert property (
        rsp_valid && rsp == SPC_RSP_ERROR && last_cmd_reg == SPC_CMD_START
        |=> !cmd_valid [*8])
        else $error("host retried too soon after error");
    retry_ok_a: assert property (
        rsp_valid && last_cmd_reg == SPC_CMD_START && err_pend_reg
        |-> rsp == SPC_RSP_OK)
        else $error("retried start not answered ok");
    start_commit_a: assert property (
        rsp_valid && rsp == SPC_RSP_OK && last_cmd_reg == SPC_CMD_START
        |-> ##[0:2] msg_type == load_prof_reg)
        else $error("started profile not reported");

    cover property (rsp_valid && rsp == SPC_RSP_ERROR
                    && last_cmd_reg == SPC_CMD_START);
    cover property (rsp_valid && rsp == SPC_RSP_OK
                    && last_cmd_reg == SPC_CMD_START);
    cover property ($rose(boot_force));
endmodule // spc_link_monitor

// File: verif/tb_top.sv
// testbench: paired host and sensor ends, plus a directly driven sensor
`timescale 1ns/100ps
module tb_top;
    import spc_pkg::*;
    logic                clock;
    logic                rst_b;
    logic                power_first;
    logic                loss_s;
    logic                fault_s;
    logic                cfg_go;
    logic [1:0]          cfg_prof;
    logic [SPC_SETW-1:0] cfg_set;
    logic                upg_go;
    logic                upg_fail;
    logic                force_boot;
    logic                done;
    logic                upg_restart;
    logic                boot_p;
    logic                run_s;
    logic                fs_s;
    logic                boot_s;
    logic                mrst_s;
    logic                mrst_seen = 1'b0;
    logic [2:0]          led_s;
    logic [SPC_IOW-1:0]  pull_s;
    int                  fail_count;
    int                  num_checks;

    spc_link_if link_p ();
    spc_link_if link_s ();

    spc_host #(.RETRY_WAIT(32'h0000_0014)) u_spc_host (
        .clock(clock), .rst_b(rst_b), .cfg_go(cfg_go), .cfg_prof(cfg_prof),
        .cfg_set(cfg_set), .upg_go(upg_go), .upg_fail(upg_fail),
        .force_boot(force_boot), .link(link_p), .busy(), .done(done),
        .upg_restart(upg_restart));
    spc_sensor u_spc_sensor (
        .clock(clock), .rst_b(rst_b), .power_first(power_first),
        .power_loss(1'b0), .fw_fault(1'b0), .io_in(4'h0), .link(link_p),
        .running(), .fail_safe(), .boot_mode(boot_p), .mcu_reset(),
        .led(), .io_pullup(), .fast_tick(), .slow_tick());
    spc_sensor u_spc_sensor_2 (
        .clock(clock), .rst_b(rst_b), .power_first(power_first),
        .power_loss(loss_s), .fw_fault(fault_s), .io_in(4'h0),
        .link(link_s), .running(run_s), .fail_safe(fs_s),
        .boot_mode(boot_s), .mcu_reset(mrst_s), .led(led_s),
        .io_pullup(pull_s), .fast_tick(), .slow_tick());
    spc_link_monitor u_spc_link_monitor (
        .clock(clock), .rst_b(rst_b), .cmd_valid(link_p.cmd_valid),
        .cmd(link_p.cmd), .cmd_prof(link_p.cmd_prof),
        .cmd_set(link_p.cmd_set), .rsp_valid(link_p.rsp_valid),
        .rsp(link_p.rsp), .msg_valid(link_p.msg_valid),
        .msg_type(link_p.msg_type), .boot_force(link_p.boot_force));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) mrst_seen <= mrst_seen | mrst_s;

    // ==========
    // tasks
    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        if (fail_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic send(input spc_cmd_t c, input logic [1:0] p,
                        input logic [15:0] s, input logic ev,
                        input spc_rsp_t er);
        @(negedge clock);
        link_s.cmd_valid = 1'b1;
        link_s.cmd = c;
        link_s.cmd_prof = p;
        link_s.cmd_set = s;
        @(negedge clock);
        link_s.cmd_valid = 1'b0;
        check("rsp_valid", link_s.rsp_valid, ev);
        if (er != SPC_RSP_NONE) begin
            check("rsp", link_s.rsp, er);
        end
        @(negedge clock);
    endtask

    task automatic pulse(ref logic s);
        @(negedge clock);
        s = 1'b1;
        @(negedge clock);
        s = 1'b0;
    endtask

    task automatic faults(input int n);
        repeat (n) pulse(fault_s);
        @(negedge clock);
    endtask

    task automatic wait_for(ref logic s, input int bound);
        int n;
        n = 0;
        num_checks++;
        while (s !== 1'b1 && n < bound) begin
            @(negedge clock);
            n++;
        end
        if (s !== 1'b1) begin
            fail_count++;
            $display("[FAIL] wait expected 1 seen %b", s);
            summarize();
        end
    endtask

    // ==========
    // main sequence
    initial begin
        fail_count = 0;
        num_checks = 0;
        rst_b = 1'b0;
        power_first = 1'b1;
        {loss_s, fault_s, cfg_go, upg_go, upg_fail, force_boot} = 6'h00;
        cfg_prof = 2'h0;
        cfg_set = 16'h0000;
        link_s.cmd_valid = 1'b0;
        link_s.cmd = SPC_CMD_NONE;
        link_s.cmd_prof = 2'h0;
        link_s.cmd_set = 16'h0000;
        link_s.boot_force = 1'b0;
        repeat (3) @(negedge clock);
        check("pullup in reset", pull_s, 4'hF);
        @(negedge clock);
        rst_b = 1'b1;
        repeat (3) @(negedge clock);
        check("running", run_s, 1'b1);
        check("led", led_s, SPC_LED_BLUE);
        check("msg_type", link_s.msg_type, SPC_DEFAULT_PROF);
        check("pullup", pull_s, 4'(~SPC_PROF_IO[3:0]));
        send(SPC_CMD_SET, 2'h0, 16'h0009, 1'b1, SPC_RSP_ERROR);
        send(SPC_CMD_LOAD, 2'h1, 16'h0000, 1'b1, SPC_RSP_ERROR);
        send(SPC_CMD_ERASE_BOOT, 2'h0, 16'h0000, 1'b1, SPC_RSP_ERROR);
        send(SPC_CMD_STOP, 2'h0, 16'h0000, 1'b1, SPC_RSP_OK);
        check("running", run_s, 1'b0);
        send(SPC_CMD_LOAD, 2'h1, 16'h0000, 1'b1, SPC_RSP_OK);
        send(SPC_CMD_SET, 2'h1, 16'h0003, 1'b1, SPC_RSP_OK);
        send(SPC_CMD_START, 2'h1, 16'h0000, 1'b1, SPC_RSP_OK);
        check("running", run_s, 1'b1);
        check("msg_type", link_s.msg_type, 2'h1);
        check("pullup", pull_s, 4'(~SPC_PROF_IO[7:4]));
        send(SPC_CMD_STOP, 2'h0, 16'h0000, 1'b1, SPC_RSP_OK);
        send(SPC_CMD_LOAD, 2'h0, 16'h0000, 1'b1, SPC_RSP_OK);
        send(SPC_CMD_SET, 2'h0, 16'h0008, 1'b1, SPC_RSP_OK);
        pulse(loss_s);
        repeat (2) @(negedge clock);
        check("msg_type", link_s.msg_type, 2'h1);
        check("pullup", pull_s, 4'(~SPC_PROF_IO[7:4]));
        send(SPC_CMD_STOP, 2'h0, 16'h0000, 1'b1, SPC_RSP_NONE);
        send(SPC_CMD_LOAD, 2'h2, 16'h0000, 1'b1, SPC_RSP_OK);
        send(SPC_CMD_START, 2'h2, 16'h0000, 1'b1, SPC_RSP_ERROR);
        wait_for(mrst_seen, 8);
        repeat (4) @(negedge clock);
        send(SPC_CMD_LOAD, 2'h2, 16'h0000, 1'b1, SPC_RSP_NONE);
        send(SPC_CMD_START, 2'h2, 16'h0000, 1'b1, SPC_RSP_OK);
        check("msg_type", link_s.msg_type, 2'h2);
        check("running", run_s, 1'b1);
        for (int i = 1; i <= SPC_FAULT_LIMIT; i++) begin
            faults(1);
            check("fail_safe", fs_s, i == SPC_FAULT_LIMIT);
        end
        check("led", led_s, SPC_LED_WHITE);
        send(SPC_CMD_STOP, 2'h0, 16'h0000, 1'b0, SPC_RSP_NONE);
        send(SPC_CMD_LOWLEVEL, 2'h0, 16'h0000, 1'b1, SPC_RSP_NONE);
        send(SPC_CMD_RESET, 2'h0, 16'h0000, 1'b1, SPC_RSP_NONE);
        repeat (2) @(negedge clock);
        check("fail_safe", fs_s, 1'b0);
        faults(SPC_FAULT_LIMIT - 1);
        pulse(loss_s);
        faults(SPC_FAULT_LIMIT - 1);
        check("fail_safe", fs_s, 1'b0);
        faults(1);
        check("fail_safe", fs_s, 1'b1);
        pulse(loss_s);
        repeat (2) @(negedge clock);
        check("fail_safe", fs_s, 1'b0);
        send(SPC_CMD_BOOT, 2'h0, 16'h0000, 1'b1, SPC_RSP_OK);
        check("boot_mode", boot_s, 1'b1);
        cfg_prof = 2'h1;
        cfg_set = 16'h0007;
        pulse(cfg_go);
        wait_for(done, 50);
        check("pair msg_type", link_p.msg_type, 2'h1);
        cfg_prof = 2'h2;
        pulse(cfg_go);
        wait_for(done, 300);
        check("pair msg_type", link_p.msg_type, 2'h2);
        check("pair boot_mode", boot_p, 1'b0);
        force_boot = 1'b1;
        repeat (3) @(negedge clock);
        check("pair boot_mode", boot_p, 1'b1);
        pulse(upg_go);
        pulse(upg_fail);
        wait_for(upg_restart, 50);
        summarize();
    end
endmodule // tb_top
